// ---- logic/rti_pkg.sv ----
// record table indexer: shared widths, limits and operation codes
// assumes one clock domain; word addresses are 16 bits wide
package rti_pkg;
  localparam int unsigned RTI_WORD_W = 16;
  localparam int unsigned RTI_ADDR_W = 16;
  localparam int unsigned RTI_NUM_TABLES = 16;
  localparam int unsigned RTI_TBL_IDX_W = 4;
  localparam int unsigned RTI_NUM_IR = 16;
  localparam int unsigned RTI_IR_IDX_W = 4;
  localparam int unsigned RTI_COUNT_SEL_BIT = 15;
  localparam logic [15:0] RTI_ZERO_WORD = 16'h0000;
  localparam logic [15:0] RTI_COUNT_ON = 16'h8000;
  localparam logic [15:0] RTI_COUNT_OFF = 16'h0000;
  localparam logic [31:0] RTI_ZERO_WIDE = 32'h0000_0000;
  localparam logic [15:0] RTI_ONE_WORD = 16'h0001;
  localparam int unsigned RTI_DIV_STEPS = 32;
  localparam logic [5:0] RTI_DIV_LAST = 6'h1F;

  typedef enum logic [2:0] {
    RTI_OP_NONE,
    RTI_OP_DEFINE,
    RTI_OP_LOCATE,
    RTI_OP_NUMBER,
    RTI_OP_SEARCH
  } rti_op_t;
endpackage : rti_pkg

// ---- logic/rti_divider.sv ----
// restoring divider, one quotient bit per clock, 32 by 16 bits
// assumes start is a single pulse while idle; divisor is nonzero
`timescale 1ns/1ps
`default_nettype none
module rti_divider (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  output logic busy,
  output logic done,
  output logic [31:0] quotient
);
  logic [31:0] quot_reg;
  logic [16:0] rem_reg;
  logic [15:0] div_reg;
  logic [5:0] step_reg;
  logic busy_reg;
  logic done_reg;
  wire [16:0] shifted = {rem_reg[15:0], quot_reg[31]};
  wire fits = shifted >= {1'b0, div_reg};
  wire [16:0] reduced = shifted - {1'b0, div_reg};

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      quot_reg <= rti_pkg::RTI_ZERO_WIDE;
      rem_reg <= 17'h00000;
      div_reg <= rti_pkg::RTI_ZERO_WORD;
      step_reg <= 6'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (start && !busy_reg)
    begin
      quot_reg <= dividend;
      rem_reg <= 17'h00000;
      div_reg <= divisor;
      step_reg <= 6'h00;
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else if (busy_reg)
    begin
      rem_reg <= fits ? reduced : shifted;
      quot_reg <= {quot_reg[30:0], fits};
      step_reg <= step_reg + 6'h01;
      busy_reg <= step_reg != rti_pkg::RTI_DIV_LAST;
      done_reg <= step_reg == rti_pkg::RTI_DIV_LAST;
    end
    else
    begin
      done_reg <= 1'b0;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign quotient = quot_reg;
endmodule : rti_divider
`default_nettype wire

// ---- logic/rti_record_table_indexer.sv ----
// record table indexer: table definitions, record address arithmetic,
// index registers and word-search operand setup
// assumes the sequencer holds op inputs steady while busy is high and
// feeds search words, at most one per clock, with search_word_valid
`timescale 1ns/1ps
`default_nettype none
module rti_record_table_indexer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic op_condition,
  input wire logic op_edge_mode,
  input wire rti_pkg::rti_op_t op_code,
  input wire logic [3:0] table_number,
  input wire logic [15:0] record_length,
  input wire logic [15:0] record_count,
  input wire logic [15:0] table_base,
  input wire logic [15:0] record_number_in,
  input wire logic [3:0] ir_select,
  input wire logic [15:0] search_control_word,
  input wire logic [15:0] search_select_word,
  input wire logic [15:0] range_first_word,
  input wire logic [15:0] comparison_word,
  input wire logic [15:0] search_word,
  input wire logic search_word_valid,
  input wire logic [3:0] ir_read_select,
  output logic [15:0] ir_read_data,
  output logic [15:0] data_register_zero,
  output logic [15:0] dest_word,
  output logic dest_word_valid,
  output logic error_flag,
  output logic equals_flag,
  output logic busy,
  output logic done
);
  typedef enum logic [1:0] {RTI_IDLE, RTI_DIVIDE, RTI_SEARCH} rti_state_t;

  rti_state_t state_reg;
  logic cond_dly_reg;
  logic [15:0] base_reg [rti_pkg::RTI_NUM_TABLES];
  logic [15:0] len_reg [rti_pkg::RTI_NUM_TABLES];
  logic [15:0] cnt_reg [rti_pkg::RTI_NUM_TABLES];
  logic [rti_pkg::RTI_NUM_TABLES-1:0] defined_reg;
  logic [15:0] ir_reg [rti_pkg::RTI_NUM_IR];
  logic [15:0] dr0_reg;
  logic [15:0] dest_reg;
  logic dest_valid_reg;
  logic err_reg;
  logic eq_reg;
  logic done_reg;
  logic [15:0] word_search_op_left_reg;
  logic [15:0] word_search_op_addr_reg;
  logic [15:0] word_search_op_hits_reg;
  logic [15:0] word_search_op_first_reg;
  logic word_search_op_count_reg;

  // every-scan or rising-edge launch
  wire fire = op_condition && (!op_edge_mode || !cond_dly_reg);
  wire launch = fire && (state_reg == RTI_IDLE);
  wire is_def = launch && (op_code == rti_pkg::RTI_OP_DEFINE);
  wire is_loc = launch && (op_code == rti_pkg::RTI_OP_LOCATE);
  wire is_num = launch && (op_code == rti_pkg::RTI_OP_NUMBER);
  wire is_word_search_op = launch && (op_code == rti_pkg::RTI_OP_SEARCH);

  wire def_bad = (record_length == rti_pkg::RTI_ZERO_WORD) ||
                 (record_count == rti_pkg::RTI_ZERO_WORD);
  wire tbl_ok = defined_reg[table_number];
  wire [15:0] sel_base = base_reg[table_number];
  wire [15:0] sel_len = len_reg[table_number];
  wire [15:0] sel_cnt = cnt_reg[table_number];
  // record numbers run 0..count-1
  wire rec_ok = record_number_in < sel_cnt;
  wire [31:0] rec_offset = record_number_in * sel_len;
  wire [15:0] rec_addr = sel_base + rec_offset[15:0];
  wire [31:0] span = sel_len * sel_cnt;
  wire [15:0] ir_val = ir_reg[ir_select];
  // wide compare so a span past the top of memory still checks correctly
  wire [31:0] ir_delta = {16'h0000, ir_val} - {16'h0000, sel_base};
  wire in_span = (ir_val >= sel_base) && (ir_delta < span);
  wire start_div = is_num && tbl_ok && in_span;
  wire word_search_op_sel = search_select_word[rti_pkg::RTI_COUNT_SEL_BIT];
  wire word_search_op_hit = search_word_valid && (search_word == comparison_word);
  wire word_search_op_last = search_word_valid &&
                   (word_search_op_left_reg == rti_pkg::RTI_ONE_WORD);
  wire div_done;
  wire [31:0] div_quot;

  rti_divider u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(start_div),
    .dividend(ir_delta),
    .divisor(sel_len),
    .busy(),
    .done(div_done),
    .quotient(div_quot)
  );

  genvar g;
  generate
    for (g = 0; g < rti_pkg::RTI_NUM_TABLES; g++)
    begin : g_tbl
      wire wr = is_def && !def_bad && (table_number == g);
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
        begin
          defined_reg[g] <= 1'b0;
          base_reg[g] <= rti_pkg::RTI_ZERO_WORD;
          len_reg[g] <= rti_pkg::RTI_ZERO_WORD;
          cnt_reg[g] <= rti_pkg::RTI_ZERO_WORD;
        end
        else if (wr)
        begin
          defined_reg[g] <= 1'b1;
          base_reg[g] <= table_base;
          len_reg[g] <= record_length;
          cnt_reg[g] <= record_count;
        end
      end
    end
    for (g = 0; g < rti_pkg::RTI_NUM_IR; g++)
    begin : g_ir
      wire loc_wr = is_loc && tbl_ok && rec_ok && (ir_select == g);
      // search done with a hit updates register zero only
      wire word_search_op_wr = (g == 0) && (state_reg == RTI_SEARCH) && word_search_op_last &&
                     ((word_search_op_hits_reg != rti_pkg::RTI_ZERO_WORD) || word_search_op_hit);
      wire [15:0] word_search_op_val = (word_search_op_hits_reg != rti_pkg::RTI_ZERO_WORD) ?
                             word_search_op_first_reg : word_search_op_addr_reg;
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          ir_reg[g] <= rti_pkg::RTI_ZERO_WORD;
        else if (loc_wr)
          ir_reg[g] <= rec_addr;
        else if (word_search_op_wr)
          ir_reg[g] <= word_search_op_val;
      end
    end
  endgenerate

  wire [15:0] hits_next = word_search_op_hits_reg + {15'h0000, word_search_op_hit};
  wire word_search_op_any = hits_next != rti_pkg::RTI_ZERO_WORD;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= RTI_IDLE;
      cond_dly_reg <= 1'b0;
      dr0_reg <= rti_pkg::RTI_ZERO_WORD;
      dest_reg <= rti_pkg::RTI_ZERO_WORD;
      dest_valid_reg <= 1'b0;
      err_reg <= 1'b0;
      eq_reg <= 1'b0;
      done_reg <= 1'b0;
      word_search_op_left_reg <= rti_pkg::RTI_ZERO_WORD;
      word_search_op_addr_reg <= rti_pkg::RTI_ZERO_WORD;
      word_search_op_hits_reg <= rti_pkg::RTI_ZERO_WORD;
      word_search_op_first_reg <= rti_pkg::RTI_ZERO_WORD;
      word_search_op_count_reg <= 1'b0;
    end
    else
    begin
      cond_dly_reg <= op_condition;
      done_reg <= 1'b0;
      dest_valid_reg <= 1'b0;
      case (state_reg)
        RTI_IDLE:
        begin
          if (is_def)
          begin
            err_reg <= def_bad;
            done_reg <= 1'b1;
          end
          else if (is_loc)
          begin
            err_reg <= !tbl_ok || !rec_ok;
            done_reg <= 1'b1;
          end
          else if (is_num)
          begin
            err_reg <= !tbl_ok || !in_span;
            if (start_div)
              state_reg <= RTI_DIVIDE;
            else
              done_reg <= 1'b1;
          end
          else if (is_word_search_op)
          begin
            err_reg <= 1'b0;
            // zero count has nothing to scan: finish as a miss
            if (search_control_word == rti_pkg::RTI_ZERO_WORD)
            begin
              eq_reg <= 1'b0;
              done_reg <= 1'b1;
            end
            else
            begin
              word_search_op_left_reg <= search_control_word;
              word_search_op_addr_reg <= range_first_word;
              word_search_op_hits_reg <= rti_pkg::RTI_ZERO_WORD;
              word_search_op_count_reg <= word_search_op_sel;
              state_reg <= RTI_SEARCH;
            end
          end
        end
        RTI_DIVIDE:
        begin
          if (div_done)
          begin
            dest_reg <= div_quot[15:0];
            dest_valid_reg <= 1'b1;
            done_reg <= 1'b1;
            state_reg <= RTI_IDLE;
          end
        end
        RTI_SEARCH:
        begin
          if (search_word_valid)
          begin
            word_search_op_hits_reg <= hits_next;
            if (word_search_op_hit && (word_search_op_hits_reg == rti_pkg::RTI_ZERO_WORD))
              word_search_op_first_reg <= word_search_op_addr_reg;
            word_search_op_addr_reg <= word_search_op_addr_reg + rti_pkg::RTI_ONE_WORD;
            word_search_op_left_reg <= word_search_op_left_reg - rti_pkg::RTI_ONE_WORD;
            if (word_search_op_last)
            begin
              eq_reg <= word_search_op_any;
              if (word_search_op_any && word_search_op_count_reg)
                dr0_reg <= hits_next;
              done_reg <= 1'b1;
              state_reg <= RTI_IDLE;
            end
          end
        end
        default:
          state_reg <= RTI_IDLE;
      endcase
    end
  end

  assign ir_read_data = ir_reg[ir_read_select];
  assign data_register_zero = dr0_reg;
  assign dest_word = dest_reg;
  assign dest_word_valid = dest_valid_reg;
  assign error_flag = err_reg;
  assign equals_flag = eq_reg;
  assign busy = state_reg != RTI_IDLE;
  assign done = done_reg;
endmodule : rti_record_table_indexer
`default_nettype wire

// ---- verification/rti_word_feeder.sv ----
// word feeder: stands in for data memory behind a word search
// assumes feed_en is high only while a search runs
`timescale 1ns/1ps
`default_nettype none
module rti_word_feeder (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic feed_en,
  input wire logic slow,
  input wire logic [15:0] count,
  output logic [15:0] search_word,
  output logic search_word_valid
);
  logic [15:0] mem [0:7];
  logic [15:0] idx_reg;
  logic gap_reg = 1'h0;
  initial
  begin
    mem = '{16'h0005, 16'h0007, 16'h0005, 16'h0009,
            16'h1111, 16'h2222, 16'h3333, 16'h4444};
    search_word = 16'h0000;
    search_word_valid = 1'h0;
  end
  always @(posedge mclk)
  begin
    // idle line toggles so a stale word never passes for data
    search_word <= ~search_word;
    search_word_valid <= 1'h0;
    gap_reg <= slow & ~gap_reg;
    if (!rst_n || !feed_en)
      idx_reg <= 16'h0000;
    else if (idx_reg < count && !gap_reg)
    begin
      search_word <= mem[idx_reg[2:0]];
      search_word_valid <= 1'h1;
      idx_reg <= idx_reg + 16'h0001;
    end
  end
endmodule : rti_word_feeder
`default_nettype wire

// ---- verification/rti_record_table_indexer_chk.sv ----
// assertions for the record table indexer, on its top ports
// assumes op inputs stay steady while busy is high
`timescale 1ns/1ps
`default_nettype none
module rti_record_table_indexer_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic op_condition,
  input wire logic op_edge_mode,
  input wire rti_pkg::rti_op_t op_code,
  input wire logic [15:0] record_length,
  input wire logic [15:0] record_count,
  input wire logic [15:0] search_control_word,
  input wire logic [15:0] data_register_zero,
  input wire logic dest_word_valid,
  input wire logic error_flag,
  input wire logic equals_flag,
  input wire logic busy,
  input wire logic done
);
  logic cond_reg;
  always_ff @(posedge mclk)
  begin
    cond_reg <= rst_n & op_condition;
  end
  wire logic take = op_condition && !busy && (!op_edge_mode || !cond_reg);
  wire logic held = op_edge_mode && op_condition && cond_reg && !busy;
  wire logic is_loc = op_code == rti_pkg::RTI_OP_LOCATE;
  wire logic is_word_search_op = op_code == rti_pkg::RTI_OP_SEARCH;
  wire logic t_def = take && op_code == rti_pkg::RTI_OP_DEFINE;
  wire logic t_num = take && op_code == rti_pkg::RTI_OP_NUMBER;
  wire logic zero_dim = record_length == 16'h0000 || record_count == 16'h0000;
  wire logic zero_word_search_op = take && is_word_search_op && search_control_word == 16'h0000;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence num_err_s;
    done && error_flag && !dest_word_valid;
  endsequence
  sequence num_long_s;
    busy ##33 done;
  endsequence
  define_err_a: assert property (t_def && zero_dim
    |=> done && error_flag)
    else $error("zero size define left error clear");
  define_ok_a: assert property (t_def && !zero_dim |=> !error_flag)
    else $error("good define raised error");
  locate_done_a: assert property (take && is_loc |=> done)
    else $error("locate not completed next cycle");
  number_time_a: assert property (t_num |=> num_err_s or num_long_s)
    else $error("lookup timing wrong");
  edge_once_a: assert property (held && is_loc |=> !done)
    else $error("edge mode op ran twice");
  miss_keep_a: assert property (done && is_word_search_op && !equals_flag
    |-> $stable(data_register_zero))
    else $error("search miss changed match count");
  busy_end_a: assert property ($fell(busy) |-> done)
    else $error("busy ended without done");
  dvalid_ok_a: assert property (dest_word_valid
    |-> done && !error_flag)
    else $error("record number written with error");
  zero_word_search_op_a: assert property (zero_word_search_op |=> done)
    else $error("empty search not completed");
endmodule : rti_record_table_indexer_chk
bind rti_record_table_indexer rti_record_table_indexer_chk chk_u (.*);
`default_nettype wire

// ---- verification/rti_record_table_indexer_tb.sv ----
// self-checking bench for the record table indexer
// assumes the word feeder model stands in for data memory
`timescale 1ns/1ps
`default_nettype none
module rti_record_table_indexer_tb;
  logic mclk = 1'h0, rst_n = 1'h0, op_condition = 1'h0, slow = 1'h0;
  logic op_edge_mode = 1'h1;
  rti_pkg::rti_op_t op_code = rti_pkg::RTI_OP_NONE;
  logic [3:0] table_number = 4'h0, ir_select = 4'h0, ir_read_select = 4'h0;
  logic [15:0] record_length = 16'h0000, record_count = 16'h0000;
  logic [15:0] table_base = 16'h0000, record_number_in = 16'h0000;
  logic [15:0] search_control_word = 16'h0000, search_select_word = 16'h0000;
  logic [15:0] range_first_word = 16'h0100, comparison_word = 16'h0000;
  logic [15:0] search_word, ir_read_data, data_register_zero, dest_word;
  logic search_word_valid, dest_word_valid, error_flag, equals_flag;
  logic busy, done, got_valid;
  int n_errors = 0, comparisons = 0;
  wire logic feed_en = busy && (op_code == rti_pkg::RTI_OP_SEARCH);
  rti_record_table_indexer dut_u (.*);
  rti_word_feeder feeder_u (.mclk(mclk), .rst_n(rst_n), .feed_en(feed_en),
    .slow(slow), .count(search_control_word), .search_word(search_word),
    .search_word_valid(search_word_valid));
  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input rti_pkg::rti_op_t op);
    int i;
    i = 0;
    @(posedge mclk);
    op_code <= op;
    op_condition <= 1'h1;
    do
    begin
      @(posedge mclk);
      #1;
      i++;
    end
    while (done !== 1'h1 && i < 80);
    got_valid = dest_word_valid;
    if (done !== 1'h1)
    begin
      n_errors++;
      $display("unexpected at %0t: no completion", $time);
      tally_and_finish();
    end
    @(posedge mclk);
    op_condition <= 1'h0;
    @(posedge mclk);
  endtask : go
  task automatic def(input logic [3:0] t, input logic [15:0] b, l, c);
    @(posedge mclk);
    table_number <= t;
    table_base <= b;
    record_length <= l;
    record_count <= c;
    go(rti_pkg::RTI_OP_DEFINE);
  endtask : def
  task automatic loc(input logic [3:0] t, input logic [15:0] r,
                     input logic [3:0] d);
    @(posedge mclk);
    table_number <= t;
    record_number_in <= r;
    ir_select <= d;
    go(rti_pkg::RTI_OP_LOCATE);
  endtask : loc
  task automatic num(input logic [3:0] t, input logic [3:0] s);
    @(posedge mclk);
    table_number <= t;
    ir_select <= s;
    go(rti_pkg::RTI_OP_NUMBER);
  endtask : num
  task automatic rd_ir(input logic [3:0] s, input logic [15:0] exp);
    @(posedge mclk);
    ir_read_select <= s;
    #1;
    chk(ir_read_data, exp);
  endtask : rd_ir
  task automatic s_undefined;
    def(4'h7, 16'h0200, 16'h0004, 16'h0000);
    chk(error_flag, 1'h1);
    def(4'h7, 16'h0200, 16'h0000, 16'h0002);
    chk(error_flag, 1'h1);
    loc(4'h7, 16'h0000, 4'h6);
    chk(error_flag, 1'h1);
    rd_ir(4'h6, 16'h0000);
    num(4'h7, 4'h6);
    chk({error_flag, got_valid}, 2'h2);
  endtask : s_undefined
  task automatic s_tables;
    for (int t = 0; t < 16; t++)
    begin
      def(t[3:0], {4'h0, t[3:0], 8'h00}, 16'(t + 1), 16'h0002);
      chk(error_flag, 1'h0);
      loc(t[3:0], 16'h0001, t[3:0]);
      chk(error_flag, 1'h0);
    end
    for (int t = 0; t < 16; t++)
      rd_ir(t[3:0], {4'h0, t[3:0], 8'h00} + 16'(t + 1));
  endtask : s_tables
  task automatic s_locate;
    def(4'h2, 16'h0300, 16'h000A, 16'h0003);
    loc(4'h2, 16'h0002, 4'hB);
    rd_ir(4'hB, 16'h0314);
    loc(4'h2, 16'h0003, 4'hB);
    chk(error_flag, 1'h1);
    loc(4'h2, 16'hFFFE, 4'hB);
    chk(error_flag, 1'h1);
    rd_ir(4'hB, 16'h0314);
  endtask : s_locate
  task automatic s_number;
    def(4'h9, 16'h0300, 16'h0001, 16'h0040);
    loc(4'h9, 16'h0005, 4'h4);
    num(4'h2, 4'h4);
    chk({error_flag, got_valid, dest_word}, 18'h10000);
    loc(4'h9, 16'h001D, 4'h4);
    num(4'h2, 4'h4);
    chk({error_flag, got_valid, dest_word}, 18'h10002);
    loc(4'h9, 16'h001E, 4'h4);
    num(4'h2, 4'h4);
    chk({error_flag, got_valid}, 2'h2);
  endtask : s_number
  // feeder words from 0100 up: 0005 0007 0005 0009
  task automatic word_search_op(input logic [15:0] n, sel, cmp, input logic s,
                      input logic [15:0] ir0, dr0, input logic eq);
    @(posedge mclk);
    search_control_word <= n;
    search_select_word <= sel;
    comparison_word <= cmp;
    slow <= s;
    go(rti_pkg::RTI_OP_SEARCH);
    rd_ir(4'h0, ir0);
    chk({equals_flag, data_register_zero}, {eq, dr0});
  endtask : word_search_op
  task automatic s_search;
    word_search_op(16'h0004, 16'h8000, 16'h0005, 1'h0,
      16'h0100, 16'h0002, 1'h1);
    word_search_op(16'h0004, 16'h0000, 16'h0009, 1'h1,
      16'h0103, 16'h0002, 1'h1);
    word_search_op(16'h0004, 16'h8000, 16'h0001, 1'h0,
      16'h0103, 16'h0002, 1'h0);
    word_search_op(16'h0003, 16'h8000, 16'h0007, 1'h1,
      16'h0101, 16'h0001, 1'h1);
    // empty range ends at once as a miss
    word_search_op(16'h0000, 16'h8000, 16'h0005, 1'h0,
      16'h0101, 16'h0001, 1'h0);
  endtask : s_search
  // mid-run reset must forget table 2 and clear index register 5
  task automatic s_reset;
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    loc(4'h2, 16'h0000, 4'h5);
    chk(error_flag, 1'h1);
    rd_ir(4'h5, 16'h0000);
  endtask : s_reset
  task automatic s_scan(input logic m, input int want);
    int n;
    n = 0;
    @(posedge mclk);
    op_edge_mode <= m;
    op_code <= rti_pkg::RTI_OP_LOCATE;
    record_number_in <= 16'h0001;
    table_number <= 4'h2;
    ir_select <= 4'h5;
    op_condition <= 1'h1;
    repeat (4)
    begin
      @(posedge mclk);
      #1;
      if (done === 1'h1)
        n++;
    end
    @(posedge mclk);
    op_condition <= 1'h0;
    op_edge_mode <= 1'h1;
    chk(n, want);
    rd_ir(4'h5, 16'h030A);
  endtask : s_scan
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    rd_ir(4'h0, 16'h0000);
    s_undefined();
    s_tables();
    s_locate();
    s_number();
    s_search();
    s_scan(1'h1, 1);
    s_scan(1'h0, 4);
    s_reset();
    tally_and_finish();
  end
endmodule : rti_record_table_indexer_tb
`default_nettype wire
